// ### logic/pfv_regs.svh
// pfv_regs.svh: command codes, field layout, reset values and limits for the
// switching-frequency and input-threshold command bank.
// assumes it is included by its bare name; definitions only.
`ifndef PFV_REGS_SVH
`define PFV_REGS_SVH

// command codes
`define PFV_CMD_RESTORE_ALL 8'h16
`define PFV_CMD_FSW 8'h33
`define PFV_CMD_VON 8'h35
`define PFV_CMD_VOFF 8'h36

// linear word layout
`define PFV_EXP_MSB 15
`define PFV_EXP_LSB 11
`define PFV_MAN_MSB 10
`define PFV_MAN_LSB 0

// threshold exponent reset value (-2, LSB of 0.25 V)
`define PFV_THR_EXP 5'h1E
// threshold decode shift, so decoded values come out in quarter volts
`define PFV_THR_SHIFT 2

// threshold hardware limits in quarter volts
`define PFV_VON_MIN_Q 16'h000A
`define PFV_VOFF_MIN_Q 16'h0009
`define PFV_THR_MAX_Q 16'h0049

// frequency request limits in kHz
`define PFV_FSW_MAX_KHZ 16'h0672

// band upper bounds (exclusive) and effective frequencies, in kHz
`define PFV_FSW_BOUNDS '{16'h00FA, 16'h012C, 16'h015E, 16'h019A, 16'h01F4, 16'h0258, \
    16'h02BC, 16'h0334, 16'h03E8, 16'h04B0, 16'h0578}
`define PFV_FSW_VALUES '{11'h0E1, 11'h113, 11'h145, 11'h177, 11'h1C2, 11'h226, \
    11'h28A, 11'h2EE, 11'h384, 11'h44C, 11'h514, 11'h5DC}
`define PFV_FSW_BANDS 11

`endif

// ### logic/pfv_pkg.sv
// pfv_pkg: types and helper functions shared by the command bank modules.
// assumes pfv_regs.svh is on the include path.
`include "pfv_regs.svh"

package pfv_pkg;

    typedef struct packed {
        logic write;        // 1 = write word / send byte, 0 = read word
        logic [7:0] code;   // command code
        logic [15:0] data;  // write word
    } pfv_cmd_t;

    typedef struct packed {
        logic [10:0] fsw_khz; // effective switching frequency
        logic [6:0] von_q;    // turn-on threshold, 0.25 V units
        logic [6:0] voff_q;   // turn-off threshold, 0.25 V units
    } pfv_hw_t;

    // smallest exponent that keeps the mantissa positive in 11 bits
    function automatic logic [15:0] pfv_auto_word(input logic [10:0] khz);
        if (khz[10]) begin
            pfv_auto_word = {5'h01, 1'b0, khz[10:1]};
        end else begin
            pfv_auto_word = {5'h00, khz};
        end
    endfunction : pfv_auto_word

    // take a quarter-volt count, already floored by the decoder, and clip it into the hardware range
    function automatic logic [6:0] pfv_thr_clip(input logic [15:0] q, input logic [15:0] min_q);
        if (q < min_q) begin
            pfv_thr_clip = min_q[6:0];
        end else if (q > `PFV_THR_MAX_Q) begin
            pfv_thr_clip = 7'(`PFV_THR_MAX_Q);
        end else begin
            pfv_thr_clip = q[6:0];
        end
    endfunction : pfv_thr_clip

    // nvm holds only the mantissa; exponent -2 makes it a quarter-volt count
    function automatic logic [15:0] pfv_nvm_q(input logic [10:0] man);
        pfv_nvm_q = man[10] ? 16'h0000 : {5'h00, man};
    endfunction : pfv_nvm_q

endpackage : pfv_pkg

// ### logic/pfv_linear_decode.sv
// pfv_linear_decode: linear word to unsigned magnitude, floored, saturating.
// assumes the caller checks neg_o; SHIFT scales the result (2 = quarter units).
`timescale 1ns/1ps
`include "pfv_regs.svh"

module pfv_linear_decode #(
    parameter int SHIFT = 0
) (
    input wire logic [15:0] word_i, // linear-format word
    output logic [15:0] value_o,    // |mantissa| * 2^(exp+SHIFT), floored
    output logic neg_o              // mantissa negative
);
    logic signed [5:0] e;
    logic [10:0] mag;
    logic [31:0] wide;

    always_comb begin
        e = $signed({word_i[`PFV_EXP_MSB], word_i[`PFV_EXP_MSB:`PFV_EXP_LSB]}) + 6'sd0 + 6'(SHIFT);
        neg_o = word_i[`PFV_MAN_MSB];
        mag = neg_o ? 11'(-word_i[`PFV_MAN_MSB:`PFV_MAN_LSB]) : word_i[`PFV_MAN_MSB:`PFV_MAN_LSB];
        wide = 32'h0;
        value_o = 16'h0;
        if (e < 6'sd0) begin
            wide = {21'h0, mag} >> 6'(-e); // RULE_17
            value_o = wide[15:0];
        end else if (e > 6'sd5) begin
            value_o = 16'hFFFF; // 11-bit magnitude shifted past 16 bits
        end else begin
            wide = {21'h0, mag} << e[2:0]; // RULE_17
            value_o = wide[15:0];
        end
    end

endmodule : pfv_linear_decode

// ### logic/pfv_freq_map.sv
// pfv_freq_map: maps a decoded frequency request onto a supported step.
// assumes khz_i is already decoded to whole kHz.
`timescale 1ns/1ps
`include "pfv_regs.svh"

module pfv_freq_map (
    input wire logic [15:0] khz_i, // requested frequency, kHz
    output logic [10:0] eff_o      // effective frequency, kHz
);
    localparam logic [15:0] BOUND [`PFV_FSW_BANDS] = `PFV_FSW_BOUNDS;
    localparam logic [10:0] VALUE [`PFV_FSW_BANDS+1] = `PFV_FSW_VALUES;

    always_comb begin
        eff_o = VALUE[`PFV_FSW_BANDS];
        // walk downward so the lowest matching band wins
        for (int i = `PFV_FSW_BANDS - 1; i >= 0; i--) begin
            if (khz_i < BOUND[i]) begin
                eff_o = VALUE[i]; // RULE_04
            end
        end
    end

endmodule : pfv_freq_map

// ### logic/pfv_top.sv
// pfv_top: switching-frequency and input turn-on/turn-off threshold commands,
// with the input-voltage start/stop supervisor that they steer.
// assumes a command front end that has already parsed bus transactions into
// single-cycle command strobes, and nvm values that are stable at reset release.
//
// Summary of operation
// RULE_01 - frequency command 33h, word access, exponent 15:11, mantissa 10:0, in kHz.
// RULE_02 - frequency write applies at once when idle, else waits for restore or undervoltage.
// RULE_03 - at reset the frequency exponent is derived from the stored frequency.
// RULE_04 - decoded frequency maps onto one of twelve supported effective steps.
// RULE_05 - host should avoid frequencies above 1100 kHz in stacked phases.
// RULE_06 - turn-on threshold command 35h in volts, exponent resets to -2.
// RULE_07 - conversion starts only once sensed input reaches the turn-on threshold.
// RULE_08 - out-of-range threshold writes are flagged as invalid data.
// RULE_09 - in-range thresholds accepted, rounded down when applied or restored.
// RULE_10 - turn-on hardware covers 2.50 V to 18.25 V in 0.25 V steps.
// RULE_11 - turn-off hardware covers 2.25 V to 18.25 V in 0.25 V steps.
// RULE_12 - low-input fault masked after power-on until input first exceeds turn-on.
// RULE_13 - only power-on reset re-arms the low-input fault mask.
// RULE_14 - turn-off threshold command 36h, exponent resets to -2.
// RULE_15 - enabled but below turn-off threshold sets the off-due-to-low-input bit.
// RULE_16 - host keeps turn-off below turn-on; device does not enforce it.
// RULE_17 - linear words decode as signed mantissa times two to signed exponent.
`timescale 1ns/1ps
`include "pfv_regs.svh"

module pfv_top
    import pfv_pkg::*;
(
    input wire logic clk_i,                   // 40 MHz clock
    input wire logic resetn_i,                // power-on reset, async, active low
    input wire logic cmd_valid_i,             // one-cycle command strobe
    input wire pfv_cmd_t cmd_i,               // command code, direction, write word
    output logic [15:0] rd_data_o,            // read word
    output logic rd_valid_o,                  // read word valid, one cycle
    output logic invalid_data_o,              // invalid data written, one cycle
    input wire logic on_off_en_i,             // on/off configuration enable met
    input wire logic analog_supply_input_supply_undervoltage_lockout_i,             // analog supply below undervoltage lockout
    input wire logic [7:0] vin_sense_q_i,     // sensed power-stage input, 0.25 V units
    input wire logic [10:0] nvm_fsw_khz_i,    // stored switching frequency, kHz
    input wire logic [10:0] nvm_start_threshold_mantissa_i,    // stored turn-on mantissa
    input wire logic [10:0] nvm_stop_threshold_mantissa_i,   // stored turn-off mantissa
    output pfv_hw_t hw_o,                     // values applied to the hardware
    output logic conv_active_o,               // power conversion running
    output logic vin_low_off_o,               // output off due to low input
    output logic low_vin_fault_o,             // unmasked low-input fault
    output logic low_vin_masked_o             // low-input fault still masked
);
    typedef enum logic {
        ST_LOAD,
        ST_RUN
    } pfv_state_t;

    // command bank state
    pfv_state_t state_ff, nxt_state;
    logic [15:0] fsw_word_ff, nxt_fsw_word;
    logic [15:0] von_word_ff, nxt_von_word;
    logic [15:0] voff_word_ff, nxt_voff_word;
    logic [10:0] fsw_pend_ff, nxt_fsw_pend;
    logic pend_ff, nxt_pend;
    pfv_hw_t hw_ff, nxt_hw;
    logic [15:0] rd_data_ff, nxt_rd_data;
    logic rd_valid_ff, nxt_rd_valid;
    logic invalid_ff, nxt_invalid;

    // supervisor state
    logic run_ff, nxt_run;
    logic mask_ff, nxt_mask;

    // decoders on the incoming word
    logic [15:0] fsw_dec, thr_dec, map_in;
    logic fsw_neg, thr_neg;
    logic [10:0] map_eff;
    logic is_write, is_read, do_load;
    logic fsw_ok, von_ok, voff_ok;

    pfv_linear_decode #(
        .SHIFT(0)
    ) u_fsw_dec (
        .word_i(cmd_i.data),
        .value_o(fsw_dec),
        .neg_o(fsw_neg)
    );

    pfv_linear_decode #(
        .SHIFT(`PFV_THR_SHIFT)
    ) u_thr_dec (
        .word_i(cmd_i.data),
        .value_o(thr_dec),
        .neg_o(thr_neg)
    );

    pfv_freq_map u_map (
        .khz_i(map_in),
        .eff_o(map_eff)
    );

    // a restore reloads every word from nvm, exactly like the power-on load
    always_comb begin
        is_write = cmd_valid_i && cmd_i.write && (state_ff == ST_RUN);
        is_read = cmd_valid_i && !cmd_i.write && (state_ff == ST_RUN);
        do_load = (state_ff == ST_LOAD) || (is_write && (cmd_i.code == `PFV_CMD_RESTORE_ALL));
        map_in = do_load ? {5'h00, nvm_fsw_khz_i} : fsw_dec;
        fsw_ok = !fsw_neg && (fsw_dec != 16'h0000) && (fsw_dec < `PFV_FSW_MAX_KHZ);
        // a fractional value above the minimum step floors to a legal step
        von_ok = !thr_neg && (thr_dec >= `PFV_VON_MIN_Q) && (thr_dec <= `PFV_THR_MAX_Q); // RULE_10
        voff_ok = !thr_neg && (thr_dec >= `PFV_VOFF_MIN_Q) && (thr_dec <= `PFV_THR_MAX_Q); // RULE_11
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_fsw_word = fsw_word_ff;
        nxt_von_word = von_word_ff;
        nxt_voff_word = voff_word_ff;
        nxt_fsw_pend = fsw_pend_ff;
        nxt_pend = pend_ff;
        nxt_hw = hw_ff;
        nxt_rd_data = rd_data_ff;
        nxt_rd_valid = 1'b0;
        nxt_invalid = 1'b0;
        case (state_ff)
            ST_LOAD: begin
                nxt_state = ST_RUN;
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_LOAD;
            end
        endcase
        // an analog supply dip lets a blocked frequency reach the hardware; a frequency write
        // in the same cycle wins when not converting, else it becomes the new pending value
        if (analog_supply_input_supply_undervoltage_lockout_i && pend_ff && !do_load) begin
            nxt_hw.fsw_khz = fsw_pend_ff; // RULE_02
            nxt_pend = 1'b0;
        end
        if (do_load) begin
            nxt_fsw_word = pfv_auto_word(nvm_fsw_khz_i); // RULE_03
            nxt_von_word = {`PFV_THR_EXP, nvm_start_threshold_mantissa_i}; // RULE_06
            nxt_voff_word = {`PFV_THR_EXP, nvm_stop_threshold_mantissa_i}; // RULE_14
            nxt_hw.fsw_khz = map_eff; // RULE_02
            nxt_hw.von_q = pfv_thr_clip(pfv_nvm_q(nvm_start_threshold_mantissa_i), `PFV_VON_MIN_Q); // RULE_09
            nxt_hw.voff_q = pfv_thr_clip(pfv_nvm_q(nvm_stop_threshold_mantissa_i), `PFV_VOFF_MIN_Q); // RULE_09
            nxt_pend = 1'b0;
        end else if (is_write) begin
            if (cmd_i.code == `PFV_CMD_FSW) begin
                if (fsw_ok) begin
                    nxt_fsw_word = cmd_i.data; // RULE_01
                    if (!run_ff) begin
                        nxt_hw.fsw_khz = map_eff; // RULE_02
                        nxt_pend = 1'b0;
                    end else begin
                        nxt_fsw_pend = map_eff; // RULE_02
                        nxt_pend = 1'b1;
                    end
                end else begin
                    nxt_invalid = 1'b1;
                end
            end else if (cmd_i.code == `PFV_CMD_VON) begin
                if (von_ok) begin
                    nxt_von_word = cmd_i.data; // RULE_06
                    nxt_hw.von_q = pfv_thr_clip(thr_dec, `PFV_VON_MIN_Q); // RULE_09
                end else begin
                    nxt_invalid = 1'b1; // RULE_08
                end
            end else if (cmd_i.code == `PFV_CMD_VOFF) begin
                // no ordering check against the turn-on threshold RULE_16
                if (voff_ok) begin
                    nxt_voff_word = cmd_i.data; // RULE_14
                    nxt_hw.voff_q = pfv_thr_clip(thr_dec, `PFV_VOFF_MIN_Q); // RULE_09
                end else begin
                    nxt_invalid = 1'b1; // RULE_08
                end
            end
        end
        if (is_read) begin
            nxt_rd_valid = 1'b1;
            if (cmd_i.code == `PFV_CMD_FSW) begin
                nxt_rd_data = fsw_word_ff; // RULE_01
            end else if (cmd_i.code == `PFV_CMD_VON) begin
                nxt_rd_data = von_word_ff;
            end else if (cmd_i.code == `PFV_CMD_VOFF) begin
                nxt_rd_data = voff_word_ff;
            end else begin
                nxt_rd_data = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_LOAD;
            fsw_word_ff <= 16'h0000;
            von_word_ff <= {`PFV_THR_EXP, 11'h000};
            voff_word_ff <= {`PFV_THR_EXP, 11'h000};
            fsw_pend_ff <= 11'h000;
            pend_ff <= 1'b0;
            hw_ff <= '0;
            rd_data_ff <= 16'h0000;
            rd_valid_ff <= 1'b0;
            invalid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            fsw_word_ff <= nxt_fsw_word;
            von_word_ff <= nxt_von_word;
            voff_word_ff <= nxt_voff_word;
            fsw_pend_ff <= nxt_fsw_pend;
            pend_ff <= nxt_pend;
            hw_ff <= nxt_hw;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            invalid_ff <= nxt_invalid;
        end
    end

    // input-voltage supervisor
    logic at_von, below_voff;

    always_comb begin
        at_von = vin_sense_q_i >= {1'b0, hw_ff.von_q};
        below_voff = vin_sense_q_i < {1'b0, hw_ff.voff_q};
        nxt_run = run_ff;
        nxt_mask = mask_ff;
        if (state_ff == ST_LOAD || !on_off_en_i || analog_supply_input_supply_undervoltage_lockout_i || below_voff) begin
            nxt_run = 1'b0;
        end else if (at_von) begin
            nxt_run = 1'b1; // RULE_07
        end
        // the mask only ever clears; nothing but reset sets it again
        if (vin_sense_q_i > {1'b0, hw_ff.von_q} && state_ff == ST_RUN) begin
            nxt_mask = 1'b0; // RULE_12 RULE_13
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_ff <= 1'b0;
            mask_ff <= 1'b1; // RULE_12
        end else begin
            run_ff <= nxt_run;
            mask_ff <= nxt_mask;
        end
    end

    assign rd_data_o = rd_data_ff;
    assign rd_valid_o = rd_valid_ff;
    assign invalid_data_o = invalid_ff;
    assign hw_o = hw_ff;
    assign conv_active_o = run_ff;
    assign vin_low_off_o = on_off_en_i && below_voff && (state_ff == ST_RUN); // RULE_15
    assign low_vin_fault_o = !mask_ff && below_voff && on_off_en_i; // RULE_12
    assign low_vin_masked_o = mask_ff;

endmodule : pfv_top

// ### tb/pfv_monitor.sv
// pfv_monitor: port-level timing checks on pfv_top.
// assumes it is bound to pfv_top and sees only its ports.
`timescale 1ns/1ps
module pfv_monitor
    import pfv_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic resetn_i, // reset, active low
    input wire logic cmd_valid_i, // command strobe
    input wire pfv_cmd_t cmd_i, // command
    input wire logic rd_valid_o, // read answer
    input wire logic invalid_data_o, // invalid write
    input wire logic on_off_en_i, // enable met
    input wire logic analog_supply_input_supply_undervoltage_lockout_i, // undervoltage
    input wire logic [7:0] vin_sense_q_i, // sensed input
    input wire pfv_hw_t hw_o, // applied values
    input wire logic conv_active_o, // converting
    input wire logic vin_low_off_o, // off, low input
    input wire logic low_vin_fault_o, // low-input fault
    input wire logic low_vin_masked_o // fault mask
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic rd_req;
    logic restore;
    assign rd_req = cmd_valid_i && !cmd_i.write;
    assign restore = cmd_valid_i && cmd_i.write && cmd_i.code == 8'h16;
    a_read_answer: assert property (rd_req |=> rd_valid_o)
        else $error("read not answered");
    a_read_cause: assert property (rd_valid_o |-> $past(rd_req))
        else $error("answer without read");
    a_invalid_keep: assert property (invalid_data_o |-> $stable(hw_o)
        && $past(cmd_valid_i && cmd_i.write)) else $error("invalid write changed hw");
    // a supply_undervoltage_lockout cycle or a restore are the only ways past the block while converting
    a_fsw_blocked: assert property ($past(conv_active_o) && !$past(analog_supply_input_supply_undervoltage_lockout_i)
        && !$past(restore) |-> $stable(hw_o.fsw_khz)) else $error("fsw moved while on");
    a_conv_start: assert property ($rose(conv_active_o) |->
        $past(on_off_en_i && vin_sense_q_i >= {1'b0, hw_o.von_q})) else $error("early start");
    a_conv_stop: assert property ($fell(conv_active_o) |-> $past(!on_off_en_i
        || analog_supply_input_supply_undervoltage_lockout_i || vin_sense_q_i < {1'b0, hw_o.voff_q})) else $error("bad stop");
    a_low_off_eq: assert property (vin_low_off_o ==
        (on_off_en_i && vin_sense_q_i < {1'b0, hw_o.voff_q})) else $error("low-off wrong");
    a_mask_clear: assert property ($fell(low_vin_masked_o) |->
        $past(vin_sense_q_i > {1'b0, hw_o.von_q})) else $error("mask cleared early");
    a_mask_sticky: assert property (!low_vin_masked_o |=> !low_vin_masked_o)
        else $error("mask re-armed");
    a_fault_gate: assert property (low_vin_fault_o |-> on_off_en_i && !low_vin_masked_o)
        else $error("fault while masked");
    a_thr_range: assert property (conv_active_o |-> hw_o.von_q inside {[7'h0A:7'h49]}
        && hw_o.voff_q inside {[7'h09:7'h49]}) else $error("threshold out of range");
    c_read: cover property (rd_valid_o);
    c_invalid: cover property (invalid_data_o);
    c_start: cover property ($rose(conv_active_o));
    c_unmask: cover property ($fell(low_vin_masked_o));
endmodule : pfv_monitor

// ### tb/pfv_host_model.sv
// pfv_host_model: host side of the command port, one word per call.
// assumes callers start no earlier than the edge after the load cycle.
`timescale 1ns/1ps
module pfv_host_model
    import pfv_pkg::*;
(
    input wire logic clk_i, // clock
    output logic cmd_valid_o, // command strobe
    output pfv_cmd_t cmd_o // command
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // single-phase host, so above 1100 kHz only the out-of-range 1650 kHz write is requested
    task automatic send(input logic wr, input logic [7:0] cd, input logic [15:0] dt);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= {wr, cd, dt};
    endtask : send
    // idle fields are inverted so a stale command never looks valid-shaped
    task automatic idle();
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= ~cmd_o;
    endtask : idle
endmodule : pfv_host_model

// ### tb/pfv_top_tb_top.sv
// pfv_top_tb_top: self-checking bench for pfv_top.
// assumes pfv_monitor and pfv_host_model are compiled before this file.
`timescale 1ns/1ps
module pfv_top_tb_top;
    logic clk_i;
    logic resetn_i = 1'b0;
    logic cmd_valid_i, rd_valid_o, invalid_data_o, conv_active_o;
    logic vin_low_off_o, low_vin_fault_o, low_vin_masked_o;
    pfv_pkg::pfv_cmd_t cmd_i;
    pfv_pkg::pfv_hw_t hw_o;
    logic [15:0] rd_data_o;
    logic on_off_en_i = 1'b0;
    logic analog_supply_input_supply_undervoltage_lockout_i = 1'b0;
    logic [7:0] vin_sense_q_i = 8'h00;
    logic [10:0] nvm_fsw_khz_i = 11'h44C;
    logic [10:0] nvm_start_threshold_mantissa_i = 11'h028;
    logic [10:0] nvm_stop_threshold_mantissa_i = 11'h024;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [16:0] exp_q[$];
    logic [16:0] want;
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    pfv_host_model host_u (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
    pfv_top dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .invalid_data_o(invalid_data_o), .on_off_en_i(on_off_en_i),
        .analog_supply_input_supply_undervoltage_lockout_i(analog_supply_input_supply_undervoltage_lockout_i), .vin_sense_q_i(vin_sense_q_i),
        .nvm_fsw_khz_i(nvm_fsw_khz_i), .nvm_start_threshold_mantissa_i(nvm_start_threshold_mantissa_i),
        .nvm_stop_threshold_mantissa_i(nvm_stop_threshold_mantissa_i), .hw_o(hw_o), .conv_active_o(conv_active_o),
        .vin_low_off_o(vin_low_off_o), .low_vin_fault_o(low_vin_fault_o),
        .low_vin_masked_o(low_vin_masked_o));
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [10:0] fmap(input int k);
        int b[11] = '{300, 350, 410, 500, 600, 700, 820, 1000, 1200, 1400, 1650};
        int v[11] = '{275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500};
        fmap = 11'h0E1;
        for (int i = 10; i >= 0; i--) begin
            if (k >= 250 && k < b[i]) fmap = 11'(v[i]);
        end
    endfunction : fmap
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic bad);
        if (bad) exp_q.push_back(17'h10000);
        host_u.send(1'b1, c, d);
        host_u.idle();
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] d);
        exp_q.push_back({1'b0, d});
        host_u.send(1'b0, c, 16'h0000);
    endtask : rd
    task automatic sup(input logic en, input logic uv, input logic [7:0] v, input logic [3:0] e);
        @(posedge clk_i);
        on_off_en_i <= en;
        analog_supply_input_supply_undervoltage_lockout_i <= uv;
        vin_sense_q_i <= v;
        @(posedge clk_i);
        #1;
        check(25'({conv_active_o, vin_low_off_o, low_vin_fault_o, low_vin_masked_o}), 25'(e));
    endtask : sup
    // answers and invalid pulses are matched in issue order
    always @(posedge clk_i) begin
        #1;
        cycles++;
        if (rd_valid_o === 1'b1 || invalid_data_o === 1'b1) begin
            want = exp_q.size() > 0 ? exp_q.pop_front() : 17'h1FFFF;
            check(25'({invalid_data_o, rd_valid_o ? rd_data_o : 16'h0000}), 25'(want));
        end
        if (cycles > 3000) begin
            fails++;
            $display("unexpected at %0t: run hung", $time);
            end_sim();
        end
    end
    initial begin
        logic [15:0] w;
        logic [10:0] fe;
        logic [15:0] cw[4];
        logic [15:0] fw[5] = '{16'h00F9, 16'h00FA, 16'h0190, 16'hFB48, 16'h0A26};
        int fk[5] = '{249, 250, 400, 420, 1100};
        logic [7:0] tc[10] = '{8'h33, 8'h33, 8'h33, 8'h35, 8'h35, 8'h36, 8'h35, 8'h36,
            8'h35, 8'h36};
        logic [15:0] tw[10] = '{16'h0000, 16'h07FF, 16'h0B39, 16'hF009, 16'hF04A, 16'hF008,
            16'hF049, 16'hF009, 16'hE853, 16'h0003};
        logic [13:0] th[10] = '{14'h1424, 14'h1424, 14'h1424, 14'h1424, 14'h1424, 14'h1424,
            14'h24A4, 14'h2489, 14'h1489, 14'h148C};
        w = 16'($urandom(32'h4FC3));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        host_u.idle();
        #1;
        check(hw_o, {11'h44C, 14'h1424});
        check(25'(low_vin_masked_o), 25'h1);
        cw[3] = 16'h0A26;
        cw[1] = 16'hF028;
        cw[2] = 16'hF024;
        rd(8'h33, cw[3]);
        rd(8'h35, cw[1]);
        rd(8'h36, cw[2]);
        rd(8'h20, 16'h0000);
        host_u.idle();
        $display("test load done");
        for (int i = 0; i < 25; i++) begin
            w = (i < 5) ? fw[i] : {5'h00, 11'($urandom_range(1, 1023))};
            fe = fmap((i < 5) ? fk[i] : int'(w[10:0]));
            wr(8'h33, w, 1'b0);
            #1;
            check(hw_o, {fe, 14'h1424});
            rd(8'h33, w);
        end
        cw[3] = w;
        $display("test frequency done");
        for (int i = 0; i < 10; i++) begin
            wr(tc[i], tw[i], i < 6);
            #1;
            check(hw_o, {fe, th[i]});
            if (i >= 6) cw[tc[i][1:0]] = tw[i];
            rd(tc[i], cw[tc[i][1:0]]);
        end
        host_u.idle();
        $display("test thresholds done");
        // turn-off stays below turn-on throughout
        sup(1'b1, 1'b0, 8'h28, 4'h1);
        sup(1'b1, 1'b0, 8'h29, 4'h9);
        sup(1'b1, 1'b0, 8'h2A, 4'h8);
        wr(8'h33, 16'h0190, 1'b0);
        #1;
        check(25'(hw_o.fsw_khz), 25'(fe));
        rd(8'h33, 16'h0190);
        host_u.idle();
        sup(1'b1, 1'b1, 8'h2A, 4'h0);
        check(25'(hw_o.fsw_khz), 25'h177);
        sup(1'b1, 1'b0, 8'h0A, 4'h6);
        sup(1'b0, 1'b0, 8'h0A, 4'h0);
        sup(1'b1, 1'b0, 8'h2A, 4'h8);
        wr(8'h16, 16'h0000, 1'b0);
        #1;
        check(hw_o, {11'h44C, 14'h1424});
        rd(8'h35, 16'hF028);
        host_u.idle();
        sup(1'b1, 1'b0, 8'h08, 4'h6);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        on_off_en_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        host_u.idle();
        #1;
        check(25'(low_vin_masked_o), 25'h1);
        check(25'(exp_q.size()), 25'h0);
        $display("test supervisor done");
        end_sim();
    end
endmodule : pfv_top_tb_top
bind pfv_top pfv_monitor mon_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rd_valid_o(rd_valid_o),
    .invalid_data_o(invalid_data_o), .on_off_en_i(on_off_en_i), .analog_supply_input_supply_undervoltage_lockout_i(analog_supply_input_supply_undervoltage_lockout_i),
    .vin_sense_q_i(vin_sense_q_i), .hw_o(hw_o), .conv_active_o(conv_active_o),
    .vin_low_off_o(vin_low_off_o), .low_vin_fault_o(low_vin_fault_o),
    .low_vin_masked_o(low_vin_masked_o));
